// [cssc_clock_control.sv]
// clock source selection and strap-driven default / lock control
`timescale 1ns/10ps
module cssc_clock_control (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   // strap pin, raw
   input  wire logic                  strap_pin,
   // control field write
   input  wire logic                  wr_valid,
   input  wire cssc_pkg::cssc_cfg_type wr_mask,
   input  wire cssc_pkg::cssc_cfg_type wr_data,
   // override bit write
   input  wire logic                  ovd_wr_valid,
   input  wire logic                  ovd_wr_data,
   // current state
   output cssc_pkg::cssc_cfg_type     cfg_q,
   output cssc_pkg::cssc_cfg_type     lock_q,
   output logic                       clock_strap_override_q,
   output logic                       strap_seen_q,
   output logic                       ready_q
);
   import cssc_pkg::*;

   typedef enum logic {ST_SETTLE, ST_RUN} cssc_state_type;

   cssc_state_type state_q;
   cssc_state_type state_d;
   logic [2:0]     cnt_q;
   logic [2:0]     cnt_d;
   cssc_cfg_type   cfg_d;
   cssc_cfg_type   lock_d;
   logic           ovd_d;
   logic           strap_d;
   logic           ready_d;
   logic           strap_level;
   logic           strap_rise;

   // bitwise merge of new data into old under a mask
   function automatic cssc_cfg_type merge(input cssc_cfg_type old_v,
                                          input cssc_cfg_type new_v,
                                          input cssc_cfg_type mask_v);
      merge = (old_v & ~mask_v) | (new_v & mask_v);
   endfunction

   // keep the old code when a selector write carries the unused code
   function automatic logic [1:0] sel_fix(input logic [1:0] old_v, input logic [1:0] new_v);
      sel_fix = (new_v == SEL_BAD) ? old_v : new_v;
   endfunction

   // lock mask for a strap level and override state
   function automatic cssc_cfg_type lock_for(input logic ovd, input logic strap);
      if (ovd)
         lock_for = '0;
      else if (strap)
         lock_for = LOCK_STRAP_HIGH;
      else
         lock_for = LOCK_STRAP_LOW;
   endfunction

   // strap synchroniser
   cssc_strap_sync u_strap_sync (
      .clk         (clk),
      .rst_n       (rst_n),
      .strap_pin   (strap_pin),
      .strap_level (strap_level),
      .strap_rise  (strap_rise)
   );

   // next-state logic: start-up sampling, writes, override, strap edge
   always_comb
   begin
      cssc_cfg_type merged;
      merged  = cfg_q;
      state_d = state_q;
      cnt_d   = cnt_q;
      cfg_d   = cfg_q;
      lock_d  = lock_q;
      ovd_d   = clock_strap_override_q;
      strap_d = strap_seen_q;
      case (state_q)
         ST_SETTLE:
         begin
            if (cnt_q == SETTLE_CYCLES - 3'h1)
            begin
               strap_d = strap_level;
               cfg_d   = strap_level ? CFG_STRAP_HIGH : CFG_STRAP_LOW;
               lock_d  = lock_for(1'h0, strap_level);
               state_d = ST_RUN;
            end
            else
               cnt_d = cnt_q + 3'h1;
         end
         default:
         begin
            // writes touch only unlocked bits
            if (wr_valid)
            begin
               merged = merge(cfg_q, wr_data, wr_mask & ~lock_q);
               merged.core_clock_source_sel = sel_fix(cfg_q.core_clock_source_sel,
                                                      merged.core_clock_source_sel);
               merged.fll_ref_sel   = sel_fix(cfg_q.fll_ref_sel, merged.fll_ref_sel);
               merged.third_ref_sel = sel_fix(cfg_q.third_ref_sel,
                                              merged.third_ref_sel);
               merged.out_c_source_sel = sel_fix(cfg_q.out_c_source_sel,
                                                 merged.out_c_source_sel);
               cfg_d = merged;
            end
            // setting the override loads its defaults into formerly locked bits
            if (ovd_wr_valid)
            begin
               ovd_d = ovd_wr_data;
               if (ovd_wr_data && !clock_strap_override_q)
                  cfg_d = merge(cfg_d, CFG_OVERRIDE, lock_q);
            end
            // strap stays a hardware input while the override is clear; relock by live level
            if (!ovd_d)
               strap_d = strap_level;
            if (strap_rise && !clock_strap_override_q)
               cfg_d.crystal_osc_on = 1'h1;
            lock_d = lock_for(ovd_d, strap_d);
         end
      endcase
      ready_d = (state_d == ST_RUN);
   end

   // state registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q                <= ST_SETTLE;
         cnt_q                  <= 3'h0;
         cfg_q                  <= CFG_STRAP_LOW;
         lock_q                 <= LOCK_STRAP_LOW;
         clock_strap_override_q <= 1'h0;
         strap_seen_q           <= 1'h0;
         ready_q                <= 1'h0;
      end
      else
      begin
         state_q                <= state_d;
         cnt_q                  <= cnt_d;
         cfg_q                  <= cfg_d;
         lock_q                 <= lock_d;
         clock_strap_override_q <= ovd_d;
         strap_seen_q           <= strap_d;
         ready_q                <= ready_d;
      end
   end

   // checks on the control behaviour
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_startup_done;
      !ready_q ##1 ready_q;
   endsequence

   sequence s_ovd_set;
      ready_q && ovd_wr_valid && ovd_wr_data && !clock_strap_override_q;
   endsequence

   a_startup_wait: assert property (s_startup_done |-> $past(ready_q, 3) == 1'h0)
      else $error("start-up sample came too early");

   a_strap_high_set: assert property (s_startup_done ##0 strap_seen_q |->
      cfg_q.core_clock_source_sel == SRC_FLL && cfg_q.crystal_osc_on &&
      cfg_q.out_e_clock_on && cfg_q.out_e_halve && cfg_q.out_e_source_sel == OUTE_OSC)
      else $error("strap high defaults wrong");

   a_strap_low_dark: assert property (s_startup_done ##0 !strap_seen_q |->
      !cfg_q.crystal_osc_on && !cfg_q.out_b_clock_on && !cfg_q.out_c_clock_on &&
      !cfg_q.out_e_clock_on && cfg_q.core_clock_source_sel == SRC_PIN)
      else $error("strap low defaults wrong");

   a_locked_hold: assert property (ready_q && wr_valid && !ovd_wr_valid &&
      !clock_strap_override_q && !strap_rise |=> (cfg_q & $past(lock_q)) ==
      ($past(cfg_q) & $past(lock_q)))
      else $error("locked field changed on write");

   a_unlocked_write: assert property (ready_q && wr_valid && wr_mask.crystal_osc_on &&
      !lock_q.crystal_osc_on && !strap_rise && !ovd_wr_valid |=>
      cfg_q.crystal_osc_on == $past(wr_data.crystal_osc_on))
      else $error("unlocked oscillator enable not written");

   a_ovd_unlocks: assert property (s_ovd_set |=> lock_q == '0)
      else $error("override did not clear locks");

   a_ovd_defaults: assert property (s_ovd_set ##0 !strap_rise |=>
      !cfg_q.out_b_halve && !cfg_q.out_e_halve && cfg_q.second_loop_on &&
      cfg_q.third_loop_on)
      else $error("override defaults not loaded");

   a_osc_rise_on: assert property (ready_q && strap_rise && !clock_strap_override_q |=>
      cfg_q.crystal_osc_on)
      else $error("strap rise did not enable oscillator");

   a_sel_legal: assert property (ready_q |-> cfg_q.core_clock_source_sel != SEL_BAD &&
      cfg_q.fll_ref_sel != SEL_BAD && cfg_q.third_ref_sel != SEL_BAD)
      else $error("selector holds unused code");

endmodule // cssc_clock_control

// [cssc_pkg.sv]
// package with field layout, codes, start-up defaults and lock masks for clock control
package cssc_pkg;

   // clocking control fields, one bit vector so masks can share the layout
   typedef struct packed {
      logic [1:0] core_clock_source_sel;
      logic [1:0] fll_ref_sel;
      logic [1:0] third_ref_sel;
      logic       second_ref_sel;
      logic       crystal_osc_on;
      logic       second_loop_on;
      logic       third_loop_on;
      logic       out_b_source_sel;
      logic [1:0] out_c_source_sel;
      logic       out_e_source_sel;
      logic       out_b_halve;
      logic       out_e_halve;
      logic       out_b_clock_on;
      logic       out_c_clock_on;
      logic       out_e_clock_on;
   } cssc_cfg_type;

   // core clock source codes
   localparam logic [1:0] SRC_PIN   = 2'h0;
   localparam logic [1:0] SRC_FLL   = 2'h1;
   localparam logic [1:0] SRC_THIRD = 2'h2;
   // frequency-locked loop reference codes
   localparam logic [1:0] FREF_PIN  = 2'h0;
   localparam logic [1:0] FREF_BIT  = 2'h1;
   localparam logic [1:0] FREF_OSC  = 2'h2;
   // third loop reference codes
   localparam logic [1:0] TREF_PIN  = 2'h0;
   localparam logic [1:0] TREF_OSC  = 2'h1;
   localparam logic [1:0] TREF_FLL  = 2'h2;
   // second loop reference codes
   localparam logic       SREF_PIN  = 1'h0;
   localparam logic       SREF_OSC  = 1'h1;
   // clock-output pin source codes
   localparam logic       OUTB_SECOND = 1'h0;
   localparam logic       OUTB_OSC    = 1'h1;
   localparam logic [1:0] OUTC_THIRD  = 2'h0;
   localparam logic [1:0] OUTC_FLL    = 2'h2;
   localparam logic       OUTE_OSC    = 1'h0;
   localparam logic       OUTE_FLL    = 1'h1;
   // illegal value of any two-bit selector
   localparam logic [1:0] SEL_BAD     = 2'h3;

   // cycles from reset release to strap sample (covers the synchroniser)
   localparam logic [2:0] SETTLE_CYCLES = 3'h3;

   // defaults with strap low and override 0: everything dark
   localparam cssc_cfg_type CFG_STRAP_LOW = '{
      core_clock_source_sel: SRC_PIN,   fll_ref_sel: FREF_PIN, third_ref_sel: TREF_PIN,
      second_ref_sel: SREF_PIN, crystal_osc_on: 1'h0, second_loop_on: 1'h0,
      third_loop_on: 1'h0, out_b_source_sel: OUTB_SECOND, out_c_source_sel: OUTC_FLL,
      out_e_source_sel: OUTE_FLL, out_b_halve: 1'h1, out_e_halve: 1'h1,
      out_b_clock_on: 1'h0, out_c_clock_on: 1'h0, out_e_clock_on: 1'h0};

   // defaults with strap high and override 0: oscillator / 2 on pin e
   localparam cssc_cfg_type CFG_STRAP_HIGH = '{
      core_clock_source_sel: SRC_FLL,   fll_ref_sel: FREF_OSC, third_ref_sel: TREF_PIN,
      second_ref_sel: SREF_PIN, crystal_osc_on: 1'h1, second_loop_on: 1'h0,
      third_loop_on: 1'h0, out_b_source_sel: OUTB_SECOND, out_c_source_sel: OUTC_FLL,
      out_e_source_sel: OUTE_OSC, out_b_halve: 1'h1, out_e_halve: 1'h1,
      out_b_clock_on: 1'h0, out_c_clock_on: 1'h0, out_e_clock_on: 1'h1};

   // defaults taken by locked fields when the override is set
   localparam cssc_cfg_type CFG_OVERRIDE = '{
      core_clock_source_sel: SRC_PIN,   fll_ref_sel: FREF_PIN, third_ref_sel: TREF_PIN,
      second_ref_sel: SREF_PIN, crystal_osc_on: 1'h1, second_loop_on: 1'h1,
      third_loop_on: 1'h1, out_b_source_sel: OUTB_SECOND, out_c_source_sel: OUTC_THIRD,
      out_e_source_sel: OUTE_OSC, out_b_halve: 1'h0, out_e_halve: 1'h0,
      out_b_clock_on: 1'h0, out_c_clock_on: 1'h0, out_e_clock_on: 1'h0};

   // locked bits with override 0, per strap level
   localparam cssc_cfg_type LOCK_STRAP_LOW = '{
      core_clock_source_sel: 2'h0, fll_ref_sel: 2'h0, third_ref_sel: 2'h0,
      second_ref_sel: 1'h0, crystal_osc_on: 1'h1, second_loop_on: 1'h1,
      third_loop_on: 1'h1, out_b_source_sel: 1'h0, out_c_source_sel: 2'h0,
      out_e_source_sel: 1'h1, out_b_halve: 1'h1, out_e_halve: 1'h1,
      out_b_clock_on: 1'h0, out_c_clock_on: 1'h0, out_e_clock_on: 1'h0};

   localparam cssc_cfg_type LOCK_STRAP_HIGH = '{
      core_clock_source_sel: 2'h3, fll_ref_sel: 2'h0, third_ref_sel: 2'h0,
      second_ref_sel: 1'h0, crystal_osc_on: 1'h0, second_loop_on: 1'h1,
      third_loop_on: 1'h1, out_b_source_sel: 1'h0, out_c_source_sel: 2'h0,
      out_e_source_sel: 1'h0, out_b_halve: 1'h1, out_e_halve: 1'h1,
      out_b_clock_on: 1'h0, out_c_clock_on: 1'h0, out_e_clock_on: 1'h0};

endpackage

// [cssc_strap_model.sv]
// strap source standing in for the board-level pull or driver
`timescale 1ns/10ps
module cssc_strap_model (
   // level on the strap pin
   output logic strap_pin
);
   // pin starts at a defined level and is never released
   initial strap_pin = 1'h0;

   // move to a new defined level, called just after a clock edge
   task automatic drive(input logic lvl);
      strap_pin = lvl;
   endtask
endmodule // cssc_strap_model

// [cssc_strap_sync.sv]
// strap pin synchroniser with rising-edge pulse
`timescale 1ns/10ps
module cssc_strap_sync (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // raw strap pin level
   input  wire logic strap_pin,
   // synchronised level and one-cycle rising pulse
   output logic      strap_level,
   output logic      strap_rise
);

   logic meta_q;
   logic meta_d;
   logic sync_q;
   logic sync_d;
   logic prev_q;
   logic prev_d;
   logic rise_q;
   logic rise_d;

   // next values; first stage only feeds the second
   always_comb
   begin
      meta_d = strap_pin;
      sync_d = meta_q;
      prev_d = sync_q;
      rise_d = sync_q & ~prev_q;
   end

   // register stages; the three level stages reset high and the pulse low, so a strap held high gives no false rise
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= 1'h1;
         sync_q <= 1'h1;
         prev_q <= 1'h1;
         rise_q <= 1'h0;
      end
      else
      begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         prev_q <= prev_d;
         rise_q <= rise_d;
      end
   end

   assign strap_level = sync_q; // second stage, ready by the start-up sample edge
   assign strap_rise  = rise_q;

endmodule // cssc_strap_sync

// [cssc_tb.sv]
// self-checking bench for the clock source and strap control block
`timescale 1ns/10ps
module testbench;
   import cssc_pkg::*;

   typedef struct {
      string        what;
      cssc_cfg_type cfg;
      cssc_cfg_type lock;
   } cssc_note_type;

   logic          clk;
   logic          rst_n;
   logic          strap_pin;
   logic          wr_valid;
   cssc_cfg_type  wr_mask;
   cssc_cfg_type  wr_data;
   logic          ovd_wr_valid;
   logic          ovd_wr_data;
   cssc_cfg_type  cfg_q;
   cssc_cfg_type  lock_q;
   logic          ovd_q;
   logic          strap_seen_q;
   logic          ready_q;
   int            errors;
   int            num_checks;
   int            seed;
   cssc_cfg_type  mdl;
   cssc_cfg_type  mlk;
   cssc_cfg_type  m;
   cssc_note_type notes[$];
   cssc_note_type n;
   event          note_ev;

   cssc_strap_model strap_u (.strap_pin(strap_pin));

   cssc_clock_control dut_u (
      .clk(clk), .rst_n(rst_n), .strap_pin(strap_pin),
      .wr_valid(wr_valid), .wr_mask(wr_mask), .wr_data(wr_data),
      .ovd_wr_valid(ovd_wr_valid), .ovd_wr_data(ovd_wr_data),
      .cfg_q(cfg_q), .lock_q(lock_q), .clock_strap_override_q(ovd_q),
      .strap_seen_q(strap_seen_q), .ready_q(ready_q));

   // 100 MHz clock
   initial
   begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   // compare one value, count it, report a mismatch
   task automatic check(input string what, input logic [18:0] seen, input logic [18:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // note the expected state and wake the watcher
   task automatic post(input string what);
      notes.push_back('{what, mdl, mlk});
      ->note_ev;
   endtask

   // watcher: oldest note against the outputs
   initial forever
   begin
      @(note_ev);
      n = notes.pop_front();
      check({n.what, " fields"}, cfg_q, n.cfg);
      check({n.what, " locks"}, lock_q, n.lock);
   end

   // reset with the strap held at a level, wait for start-up
   task automatic do_reset(input logic lvl);
      rst_n = 1'h0;
      strap_u.drive(lvl);
      repeat (12) @(posedge clk);
      #1 rst_n = 1'h1;
      repeat (20)
      begin
         @(posedge clk);
         #1;
         if (ready_q === 1'h1)
            break;
      end
      mdl = lvl ? CFG_STRAP_HIGH : CFG_STRAP_LOW;
      mlk = lvl ? LOCK_STRAP_HIGH : LOCK_STRAP_LOW;
      post("start-up");
      check("ready", {18'h0, ready_q}, 19'h1);
      check("strap seen", {18'h0, strap_seen_q}, {18'h0, lvl});
   endtask

   // one field write; keep marks a refused selector code
   task automatic wr(input cssc_cfg_type mk, input cssc_cfg_type d, input logic keep);
      logic [18:0] en;
      @(posedge clk);
      #1 wr_valid = 1'h1;
      wr_mask = mk;
      wr_data = d;
      @(posedge clk);
      #1 wr_valid = 1'h0;
      en = mk & ~mlk;
      if (!keep)
         mdl = (mdl & ~en) | (d & en);
      post("write");
   endtask

   // override write; setting it loads defaults into bits that were locked
   task automatic ovd(input logic v);
      @(posedge clk);
      #1 ovd_wr_valid = 1'h1;
      ovd_wr_data = v;
      @(posedge clk);
      #1 ovd_wr_valid = 1'h0;
      if (v)
         mdl = (mdl & ~mlk) | (CFG_OVERRIDE & mlk);
      mlk = v ? '0 : (strap_pin ? LOCK_STRAP_HIGH : LOCK_STRAP_LOW);
      post("override");
      check("override", {18'h0, ovd_q}, {18'h0, v});
   endtask

   // random fields, selectors kept to legal codes
   function automatic cssc_cfg_type rnd();
      cssc_cfg_type r;
      r = cssc_cfg_type'(19'($random(seed)));
      r.core_clock_source_sel = 2'(($random(seed) & 32'h7FFF) % 3);
      r.fll_ref_sel = 2'(($random(seed) & 32'h7FFF) % 3);
      r.third_ref_sel = 2'(($random(seed) & 32'h7FFF) % 3);
      r.out_c_source_sel = 2'(($random(seed) & 32'h7FFF) % 3);
      return r;
   endfunction

   // verdict and end of run
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // watchdog
   initial
   begin
      #200000;
      errors++;
      results();
   end

   // main sequence
   initial
   begin
      seed = 32'hA84C;
      errors = 0;
      num_checks = 0;
      rst_n = 1'h0;
      wr_valid = 1'h0;
      wr_mask = '0;
      wr_data = '0;
      ovd_wr_valid = 1'h0;
      ovd_wr_data = 1'h0;
      do_reset(1'h0);
      repeat (4) wr('1, rnd(), 1'h0);
      $display("test strap low locks done");
      @(posedge clk);
      #1 strap_u.drive(1'h1);
      repeat (6) @(posedge clk);
      #1 mdl.crystal_osc_on = 1'h1;
      mlk = LOCK_STRAP_HIGH;
      post("strap rise");
      m = '0;
      m.crystal_osc_on = 1'h1;
      wr(m, '0, 1'h0);
      $display("test strap rise done");
      do_reset(1'h1);
      repeat (4) wr('1, rnd(), 1'h0);
      $display("test strap high locks done");
      ovd(1'h1);
      repeat (4) wr('1, rnd(), 1'h0);
      m = '0;
      m.core_clock_source_sel = SEL_BAD;
      m.fll_ref_sel = SEL_BAD;
      m.third_ref_sel = SEL_BAD;
      m.out_c_source_sel = SEL_BAD;
      wr(m, m, 1'h1);
      @(posedge clk);
      #1 strap_u.drive(1'h0);
      repeat (6) @(posedge clk);
      #1 post("strap ignored");
      ovd(1'h0);
      wr('1, rnd(), 1'h0);
      $display("test override done");
      repeat (2) @(posedge clk);
      results();
   end
endmodule // testbench
